// >>> fcp_defines.svh
`ifndef FCP_DEFINES_SVH
`define FCP_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define FCP_OFS_CMD    8'h00
`define FCP_OFS_ADDR   8'h04
`define FCP_OFS_DATA   8'h08
`define FCP_OFS_PAGE   8'h0C
`define FCP_OFS_GUARD  8'h10
`define FCP_OFS_STAT   8'h14
`define FCP_OFS_CFG    8'h18
`define FCP_OFS_MAP    8'h1C

// ****************************************
// Command codes
// ****************************************
`define FCP_CMD_VERIFY 8'h05
`define FCP_CMD_PROG   8'h20
`define FCP_CMD_SECT   8'h40
`define FCP_CMD_MASS   8'h41

// ****************************************
// Reset values
// ****************************************
`define FCP_GUARD_RST  8'h00
`define FCP_PAGE_RST   8'h38

// ****************************************
// Array geometry
// ****************************************
`define FCP_ERASED     16'hFFFF
`define FCP_LAST_WORD  16'hFFFF
`define FCP_SECT_MASK  17'h1FC00
`define FCP_PAGE_BASE  5'h07
`define FCP_BLK_LOWWIN 3'h5
`define FCP_BLK_LOWPRT 3'h6
`define FCP_BLK_HIPRT  3'h7
`define FCP_BLK_BYTES  17'h04000
`define FCP_LOW_UNIT   17'h00400
`define FCP_HIGH_UNIT  17'h00800

`endif

// >>> fcp_pkg.sv
package fcp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PROG,
        ST_SECT,
        ST_MASS,
        ST_VRD,
        ST_VWAIT,
        ST_VCHK
    } fcp_state_t;

    typedef struct packed {
        logic       guard_open;
        logic       rsv;
        logic       high_range_guard_disable;
        logic [1:0] high_size;
        logic       low_range_guard_disable;
        logic [1:0] low_size;
    } fcp_guard_t;

    typedef struct packed {
        logic prot_viol;
        logic acc_err;
        logic blank;
        logic done;
        logic busy;
    } fcp_status_t;

    typedef struct packed {
        logic        rd;
        logic        prog;
        logic        sect;
        logic        mass;
        logic [16:0] addr;
        logic [15:0] wdata;
    } fcp_array_req_t;

endpackage : fcp_pkg

// >>> fcp_addr_map.sv
`timescale 1ns/10ps
`include "fcp_defines.svh"

module fcp_addr_map
    import fcp_pkg::*;
(
    input  wire logic [15:0] cpu_addr_i,
    input  wire logic [7:0]  page_i,
    input  wire logic        low_win_en_i,
    input  fcp_guard_t       guard_i,
    output logic      [16:0] arr_addr_o,
    output logic             map_ok_o,
    output logic             guarded_o
);

    // ****************************************
    // Guarded span in bytes
    // ****************************************
    function automatic logic [16:0] guard_span(input logic [1:0] sz, input logic high);
        guard_span = high ? (`FCP_HIGH_UNIT << sz) : (`FCP_LOW_UNIT << sz);
    endfunction : guard_span

    logic [2:0]  blk;
    logic [16:0] offs;

    always_comb begin
        offs = {3'b000, cpu_addr_i[13:0]};
        case (cpu_addr_i[15:14])
            2'b00: begin
                blk      = `FCP_BLK_LOWWIN;
                map_ok_o = low_win_en_i;
            end
            2'b01: begin
                blk      = `FCP_BLK_LOWPRT;
                map_ok_o = 1'b1;
            end
            2'b10: begin
                blk      = page_i[2:0];
                map_ok_o = (page_i[7:3] == `FCP_PAGE_BASE);
            end
            default: begin
                blk      = `FCP_BLK_HIPRT;
                map_ok_o = 1'b1;
            end
        endcase
        arr_addr_o = {blk, cpu_addr_i[13:0]};
        guarded_o  = 1'b0;
        if (blk == `FCP_BLK_LOWPRT && !guard_i.low_range_guard_disable &&
            offs < guard_span(guard_i.low_size, 1'b0)) begin
            guarded_o = 1'b1;
        end
        if (blk == `FCP_BLK_HIPRT && !guard_i.high_range_guard_disable &&
            offs >= `FCP_BLK_BYTES - guard_span(guard_i.high_size, 1'b1)) begin
            guarded_o = 1'b1;
        end
    end

endmodule : fcp_addr_map

// >>> fcp_flash_ctrl.sv
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "fcp_defines.svh"

module fcp_flash_ctrl
    import fcp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [15:0] array_rdata_i,
    output fcp_array_req_t   array_req_o,
    output logic             busy_o
);

    // ****************************************
    // Byte lane merge
    // ****************************************
    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
        lane16[7:0]  = sel[0] ? nw[7:0] : old[7:0];
        lane16[15:8] = sel[1] ? nw[15:8] : old[15:8];
    endfunction : lane16

    fcp_state_t     state_reg,     state_next;
    fcp_status_t    stat_reg,      stat_next;
    fcp_guard_t     flash_guard_register_reg, flash_guard_register_next;
    fcp_array_req_t req_reg,       req_next;
    logic [7:0]     flash_command_code_reg,   flash_command_code_next;
    logic [7:0]     program_page_select_reg,  program_page_select_next;
    logic [15:0]    addr_reg,      addr_next;
    logic [15:0]    wdata_reg,     wdata_next;
    logic [15:0]    idx_reg,       idx_next;
    logic           all_erased_reg, all_erased_next;
    logic           low_win_reg,   low_win_next;
    logic           ack_reg,       ack_next;
    logic [31:0]    dat_reg,       dat_next;
    logic [16:0]    mapped;
    logic           map_ok;
    logic           guarded;
    logic           wr;
    logic           cmd_wr;
    logic           bad_code;
    logic           refused;
    logic           mass_ok;

    // ****************************************
    // Address mapping
    // ****************************************
    fcp_addr_map u_map (
        .cpu_addr_i   (addr_reg),
        .page_i       (program_page_select_reg),
        .low_win_en_i (low_win_reg),
        .guard_i      (flash_guard_register_reg),
        .arr_addr_o   (mapped),
        .map_ok_o     (map_ok),
        .guarded_o    (guarded)
    );

    // ****************************************
    // Bus and command sequencer
    // ****************************************
    always_comb begin
        state_next                = state_reg;
        stat_next                 = stat_reg;
        flash_guard_register_next = flash_guard_register_reg;
        flash_command_code_next   = flash_command_code_reg;
        program_page_select_next  = program_page_select_reg;
        addr_next                 = addr_reg;
        wdata_next                = wdata_reg;
        idx_next                  = idx_reg;
        all_erased_next           = all_erased_reg;
        low_win_next              = low_win_reg;
        req_next                  = '0;
        req_next.addr             = req_reg.addr;
        req_next.wdata            = req_reg.wdata;
        bad_code                  = 1'b0;
        refused                   = 1'b0;
        mass_ok                   = flash_guard_register_reg.low_range_guard_disable &&
                                    flash_guard_register_reg.high_range_guard_disable &&
                                    flash_guard_register_reg.guard_open;
        wr       = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
        cmd_wr   = wr && (wb_adr_i == `FCP_OFS_CMD) && wb_sel_i[0];
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        dat_next = 32'h0000_0000;
        if (ack_next) begin
            case (wb_adr_i)
                `FCP_OFS_CMD:   dat_next = {24'h000000, flash_command_code_reg};
                `FCP_OFS_ADDR:  dat_next = {16'h0000, addr_reg};
                `FCP_OFS_DATA:  dat_next = {16'h0000, wdata_reg};
                `FCP_OFS_PAGE:  dat_next = {24'h000000, program_page_select_reg};
                `FCP_OFS_GUARD: dat_next = {24'h000000, flash_guard_register_reg};
                `FCP_OFS_STAT:  dat_next = {27'h0000000, stat_reg};
                `FCP_OFS_CFG:   dat_next = {31'h00000000, low_win_reg};
                `FCP_OFS_MAP:   dat_next = {15'h0000, mapped};
                default:        dat_next = 32'h0000_0000;
            endcase
        end
        // Writes act on the edge that sees ack high
        if (wr) begin
            case (wb_adr_i)
                `FCP_OFS_ADDR: addr_next  = lane16(addr_reg, wb_dat_i, wb_sel_i);
                `FCP_OFS_DATA: wdata_next = lane16(wdata_reg, wb_dat_i, wb_sel_i);
                `FCP_OFS_PAGE: begin
                    if (wb_sel_i[0]) begin
                        program_page_select_next = wb_dat_i[7:0];
                    end
                end
                `FCP_OFS_GUARD: begin
                    if (wb_sel_i[0]) begin
                        flash_guard_register_next     = wb_dat_i[7:0];
                        flash_guard_register_next.rsv = 1'b0;
                    end
                end
                `FCP_OFS_STAT: begin
                    if (wb_sel_i[0]) begin
                        stat_next = stat_reg & ~{wb_dat_i[4:1], 1'b0};
                    end
                end
                `FCP_OFS_CFG: begin
                    if (wb_sel_i[0]) begin
                        low_win_next = wb_dat_i[0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Flags set after the clear so a set wins
        if (cmd_wr) begin
            if (state_reg != ST_IDLE) begin
                stat_next.acc_err = 1'b1;
            end else begin
                flash_command_code_next = wb_dat_i[7:0];
                stat_next.done          = 1'b0;
                case (wb_dat_i[7:0])
                    `FCP_CMD_VERIFY: begin
                        idx_next        = 16'h0000;
                        all_erased_next = 1'b1;
                        stat_next.blank = 1'b0;
                        state_next      = ST_VRD;
                    end
                    `FCP_CMD_PROG, `FCP_CMD_SECT: begin
                        if (!map_ok) begin
                            stat_next.acc_err = 1'b1;
                        end else if (guarded) begin
                            refused             = 1'b1;
                            stat_next.prot_viol = 1'b1;
                        end else if (wb_dat_i[7:0] == `FCP_CMD_PROG) begin
                            req_next.addr  = {mapped[16:1], 1'b0};
                            req_next.wdata = wdata_reg;
                            state_next     = ST_PROG;
                        end else begin
                            req_next.addr = mapped & `FCP_SECT_MASK;
                            state_next    = ST_SECT;
                        end
                    end
                    `FCP_CMD_MASS: begin
                        if (mass_ok) begin
                            state_next = ST_MASS;
                        end else begin
                            refused             = 1'b1;
                            stat_next.prot_viol = 1'b1;
                        end
                    end
                    default: begin
                        bad_code          = 1'b1;
                        stat_next.acc_err = 1'b1;
                    end
                endcase
            end
        end
        case (state_reg)
            ST_IDLE: begin
            end
            ST_PROG: begin
                req_next.prog  = 1'b1;
                stat_next.done = 1'b1;
                state_next     = ST_IDLE;
            end
            ST_SECT: begin
                req_next.sect  = 1'b1;
                stat_next.done = 1'b1;
                state_next     = ST_IDLE;
            end
            ST_MASS: begin
                req_next.mass  = 1'b1;
                stat_next.done = 1'b1;
                state_next     = ST_IDLE;
            end
            ST_VRD: begin
                req_next.rd   = 1'b1;
                req_next.addr = {idx_reg, 1'b0};
                state_next    = ST_VWAIT;
            end
            ST_VWAIT: begin
                state_next = ST_VCHK;
            end
            ST_VCHK: begin
                if (array_rdata_i != `FCP_ERASED) begin
                    all_erased_next = 1'b0;
                end
                if (idx_reg == `FCP_LAST_WORD) begin
                    stat_next.blank = all_erased_reg &&
                                      (array_rdata_i == `FCP_ERASED);
                    stat_next.done  = 1'b1;
                    state_next      = ST_IDLE;
                end else begin
                    idx_next   = idx_reg + 16'h0001;
                    state_next = ST_VRD;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        stat_next.busy = (state_next != ST_IDLE);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg                <= ST_IDLE;
            stat_reg                 <= '0;
            flash_guard_register_reg <= `FCP_GUARD_RST;
            flash_command_code_reg   <= 8'h00;
            program_page_select_reg  <= `FCP_PAGE_RST;
            addr_reg                 <= 16'h0000;
            wdata_reg                <= 16'h0000;
            idx_reg                  <= 16'h0000;
            all_erased_reg           <= 1'b0;
            low_win_reg              <= 1'b0;
            req_reg                  <= '0;
            ack_reg                  <= 1'b0;
            dat_reg                  <= 32'h0000_0000;
        end else begin
            state_reg                <= state_next;
            stat_reg                 <= stat_next;
            flash_guard_register_reg <= flash_guard_register_next;
            flash_command_code_reg   <= flash_command_code_next;
            program_page_select_reg  <= program_page_select_next;
            addr_reg                 <= addr_next;
            wdata_reg                <= wdata_next;
            idx_reg                  <= idx_next;
            all_erased_reg           <= all_erased_next;
            low_win_reg              <= low_win_next;
            req_reg                  <= req_next;
            ack_reg                  <= ack_next;
            dat_reg                  <= dat_next;
        end
    end

    assign wb_ack_o    = ack_reg;
    assign wb_dat_o    = dat_reg;
    assign array_req_o = req_reg;
    assign busy_o      = stat_reg.busy;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_last_good;
        state_reg == ST_VCHK && idx_reg == `FCP_LAST_WORD && all_erased_reg &&
        array_rdata_i == `FCP_ERASED;
    endsequence

    sequence s_prog_launch;
        cmd_wr && state_reg == ST_IDLE && wb_dat_i[7:0] == `FCP_CMD_PROG && map_ok && !guarded;
    endsequence

    a_verify_blank_set: assert property (s_last_good |=> stat_reg.blank && !busy_o)
        else $error("blank not set after clean verify");
    a_prog_one_pulse: assert property (s_prog_launch |=>
        ##1 array_req_o.prog ##1 !array_req_o.prog)
        else $error("program pulse wrong");
    a_sect_aligned: assert property (array_req_o.sect |->
        array_req_o.addr[9:0] == 10'h000)
        else $error("sector erase not aligned");
    a_mass_gated: assert property (array_req_o.mass |-> $past(mass_ok, 2))
        else $error("mass erase without guard bits");
    a_map_paged_win: assert property ((addr_reg[15:14] == 2'b10 &&
        program_page_select_reg[7:3] == `FCP_PAGE_BASE) |->
        map_ok && mapped[16:14] == program_page_select_reg[2:0]
        && mapped[13:0] == addr_reg[13:0])
        else $error("paged window mapped wrong");
    a_map_fixed_win: assert property (
        (addr_reg[15:14] == 2'b01 |-> mapped[16:14] == 3'h6) and
        (addr_reg[15:14] == 2'b11 |-> mapped[16:14] == 3'h7))
        else $error("fixed window mapped wrong");
    a_low_guard_base: assert property ((mapped == 17'h18000 &&
        !flash_guard_register_reg.low_range_guard_disable) |-> guarded)
        else $error("low range base not guarded");
    a_high_guard_top: assert property ((mapped == 17'h1FFFF &&
        !flash_guard_register_reg.high_range_guard_disable) |-> guarded)
        else $error("high range top not guarded");
    a_low_win_map: assert property (addr_reg[15:14] == 2'b00 |->
        map_ok == low_win_reg && !guarded && mapped[16:14] == 3'h5)
        else $error("low window mapped wrong");
    a_bad_code_err: assert property (bad_code |=> stat_reg.acc_err && !busy_o &&
        {array_req_o.rd, array_req_o.prog, array_req_o.sect, array_req_o.mass} == 4'h0 [*3])
        else $error("bad code not refused");
    a_guard_refuse: assert property (refused |=> stat_reg.prot_viol &&
        ({array_req_o.rd, array_req_o.prog, array_req_o.sect, array_req_o.mass} == 4'h0) [*3])
        else $error("guarded command not refused");

endmodule : fcp_flash_ctrl

// >>> tb_flash_command_and_page_map.sv
`timescale 1ns/10ps
`include "fcp_defines.svh"

module tb_flash_command_and_page_map
    import fcp_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    logic           clk_i;
    logic           rst_i;
    logic           cyc, stb, we;
    logic [7:0]     adr;
    logic [3:0]     sel;
    logic [31:0]    dat_w;
    logic [31:0]    wb_dat_o;
    logic           wb_ack_o;
    logic [15:0]    array_rdata_i = 16'hFFFF;
    fcp_array_req_t array_req_o;
    logic           busy_o;
    int             error_cnt, tests_run, n_prog, n_sect, n_mass;
    logic [16:0]    p_addr;
    logic [15:0]    p_data;
    logic [16:0]    rd_q[$];
    logic [31:0]    seed;

    fcp_flash_ctrl dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .array_rdata_i(array_rdata_i), .array_req_o(array_req_o),
        .busy_o(busy_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ****************************************
    // Array side monitor
    // ****************************************
    always @(posedge clk_i) begin
        if (array_req_o.prog === 1'b1) begin
            n_prog++;
            p_addr = array_req_o.addr;
            p_data = array_req_o.wdata;
        end
        if (array_req_o.sect === 1'b1) begin
            n_sect++;
            p_addr = array_req_o.addr;
        end
        if (array_req_o.mass === 1'b1) n_mass++;
        if (array_req_o.rd === 1'b1) begin
            rd_q.push_back(array_req_o.addr);
            array_rdata_i <= 16'hFFFF; // Array reads erased
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [17:0] exp_map(logic [15:0] a, logic [7:0] pg, logic le);
        logic [16:0] off;
        off = {3'h0, a[13:0]};
        case (a[15:14])
            2'b00:   return {le, 17'h14000 + off};
            2'b01:   return {1'b1, 17'h18000 + off};
            2'b10:   return {(pg >= 8'h38 && pg <= 8'h3F), {pg[2:0], 14'h0000} + off};
            default: return {1'b1, 17'h1C000 + off};
        endcase
    endfunction : exp_map

    function automatic logic exp_guard(logic [16:0] m, logic [7:0] g);
        logic [14:0] o;
        o = {1'b0, m[13:0]};
        return (!g[2] && m[16:14] == 3'h6 && o < (15'h0400 << g[1:0])) ||
               (!g[5] && m[16:14] == 3'h7 && o >= 15'h4000 - (15'h0800 << g[4:3]));
    endfunction : exp_guard

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        sel   <= 4'h3;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk("ack", 1, 0);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic launch(input logic [7:0] code, output logic [31:0] st);
        int n;
        logic [31:0] q;
        wb(1'b1, `FCP_OFS_CMD, {24'h0, code}, q);
        n = 0;
        @(posedge clk_i);
        while (busy_o !== 1'b0 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
        wb(1'b0, `FCP_OFS_STAT, 0, st);
    endtask : launch

    task automatic try_op(input logic [15:0] a, input logic [7:0] pg, input logic [7:0] g,
                          input logic le, input logic [7:0] code);
        logic [31:0] q;
        logic [17:0] m;
        logic        gd;
        logic [15:0] d;
        int          np, ns;
        d = rnd();
        wb(1'b1, `FCP_OFS_ADDR, {16'h0, a}, q);
        wb(1'b1, `FCP_OFS_PAGE, {24'h0, pg}, q);
        wb(1'b1, `FCP_OFS_GUARD, {24'h0, g}, q);
        wb(1'b1, `FCP_OFS_CFG, {31'h0, le}, q);
        wb(1'b1, `FCP_OFS_DATA, {16'h0, d}, q);
        wb(1'b1, `FCP_OFS_STAT, 32'h1E, q);
        m  = exp_map(a, pg, le);
        gd = exp_guard(m[16:0], g);
        if (m[17]) begin
            wb(1'b0, `FCP_OFS_MAP, 0, q);
            chk("map", {15'h0, m[16:0]}, q);
        end
        np = n_prog;
        ns = n_sect;
        launch(code, q);
        chk("flags", {!m[17], m[17] && gd}, {q[3], q[4]});
        chk("pulses", (m[17] && !gd), (n_prog - np) + (n_sect - ns));
        if (m[17] && !gd && code == `FCP_CMD_PROG) begin
            chk("prog addr", {m[16:1], 1'b0}, p_addr);
            chk("prog data", d, p_data);
        end
        if (m[17] && !gd && code == `FCP_CMD_SECT)
            chk("sect addr", m[16:0] & `FCP_SECT_MASK, p_addr);
    endtask : try_op

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        complete_run();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin : main
        logic [31:0] q;
        logic [15:0] ca[11] = '{16'h43FE, 16'h4400, 16'h5FFE, 16'h6000, 16'hF800, 16'hF7FE,
                                16'hC000, 16'h83FE, 16'hB800, 16'h0000, 16'h0000};
        logic [7:0]  cp[11] = '{8'h3E, 8'h3E, 8'h3E, 8'h3E, 8'h3F, 8'h3F,
                                8'h3F, 8'h3E, 8'h3F, 8'h38, 8'h38};
        logic [7:0]  cg[11] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00,
                                8'h18, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0]  mg[4]  = '{8'h24, 8'hA0, 8'h84, 8'hA4};
        logic [7:0]  bad[5] = '{8'h00, 8'h06, 8'h21, 8'h42, 8'hFF};
        int          nm;
        {cyc, stb, we, adr, sel, dat_w} = '0;
        seed = 32'd12930;
        error_cnt = 0;
        tests_run = 0;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;

        wb(1'b0, `FCP_OFS_GUARD, 0, q);
        chk("guard rst", {24'h0, `FCP_GUARD_RST}, q);
        wb(1'b0, `FCP_OFS_PAGE, 0, q);
        chk("page rst", {24'h0, `FCP_PAGE_RST}, q);
        wb(1'b0, `FCP_OFS_STAT, 0, q);
        chk("stat rst", 0, q);
        wb(1'b0, 8'h20, 0, q);
        chk("unmapped", 0, q);
        $display("test reset done");

        for (int i = 0; i < 4; i++) begin
            wb(1'b1, `FCP_OFS_GUARD, {24'h0, mg[i]}, q);
            wb(1'b1, `FCP_OFS_STAT, 32'h1E, q);
            nm = n_mass;
            launch(`FCP_CMD_MASS, q);
            chk("mass pulse", (i == 3), n_mass - nm);
            chk("mass viol", (i != 3), q[4]);
        end
        $display("test mass done");

        for (int i = 0; i < 5; i++) begin
            wb(1'b1, `FCP_OFS_STAT, 32'h1E, q);
            nm = n_prog + n_sect + n_mass;
            launch(bad[i], q);
            chk("bad code err", 1, q[3]);
            chk("bad code pulse", 0, n_prog + n_sect + n_mass - nm);
        end
        $display("test codes done");

        for (int i = 0; i < 11; i++)
            try_op(ca[i], cp[i], cg[i], (i == 9), `FCP_CMD_PROG);
        for (int i = 0; i < 40; i++) begin
            q = rnd();
            try_op(rnd(), (q[7:4] == 0) ? q[15:8] : 8'h38 + q[2:0], q[23:16] & 8'hBF, q[24],
                   q[25] ? `FCP_CMD_PROG : `FCP_CMD_SECT);
        end
        $display("test map done");

        wb(1'b1, `FCP_OFS_STAT, 32'h1E, q);
        rd_q.delete();
        wb(1'b1, `FCP_OFS_CMD, {24'h0, `FCP_CMD_VERIFY}, q);
        repeat (10) @(posedge clk_i);
        chk("verify busy", 1, busy_o);
        chk("verify reads", 1, rd_q.size() >= 3);
        if (rd_q.size() >= 3)
            chk("verify addr", 17'h00004, rd_q[2]);
        wb(1'b1, `FCP_OFS_CMD, {24'h0, `FCP_CMD_PROG}, q);
        wb(1'b0, `FCP_OFS_STAT, 0, q);
        chk("busy refuse", 2'b11, {q[3], q[0]});
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("busy after rst", 0, busy_o);
        wb(1'b0, `FCP_OFS_STAT, 0, q);
        chk("stat after rst", 0, q);
        $display("test verify done");
        complete_run();
    end
endmodule : tb_flash_command_and_page_map
